// file: hdl/flash_seq_cfg.svh
// constants for the flash self-write sequencer
// Summary of operation
// R1 - operations start only after keys 55h then AAh, then the write start bit
// R2 - any other access between keys and start bit cancels the operation
// R3 - a valid start forces the next two instructions to no-operations
// R4 - row erase or program stalls the core until done, about 2 ms
// R5 - latch load inserts the two no-operations, then runs without stall
// R6 - during the stall clocks and peripherals run; only the core halts
// R7 - after the stall the core resumes at the third following instruction
// R8 - erase select, write enable, program space and row address pick an erase
// R9 - program flash is erased only in whole rows
// R10 - a program operation never erases anything by itself
// R11 - upper address bits give the row, low five bits the latch
// R12 - one program writes at most 32 words and stays inside the row
// R13 - every erase or program ends by setting all latches to 3FFF
// R14 - with latch load only set, a start only loads the addressed latch
// R15 - with latch load only clear, load the latch then program the row
// R16 - erase, latch load, program and user id program all need the unlock
// R17 - software sets write enable, clears config select, loads address and data
// R18 - software steps the address by one after each latch load
// R19 - software should disable interrupts around the unlock sequence
// R20 - software programs only erased or never written words
// R21 - start bits are set by software and cleared by hardware when done
// R22 - a reset during a write sets the write abort flag
// R23 - a read uses the second instruction cycle, data follows next cycle
// R24 - config select steers accesses to user id, device id, config words
// R25 - with write enable clear a completed unlock starts nothing; the code still sets the write start bit and forces the two no-operations
`ifndef FLASH_SEQ_CFG_SVH
`define FLASH_SEQ_CFG_SVH
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'hAA
`define LATCH_BLANK 14'h3FFF
`define LATCH_COUNT 32
`define LATCH_LAST 5'h1F
`define IDX_ZERO 5'h00
`define ROW_ZERO 10'h000
`define NOP_LAST 2'h1
`define CLK_MHZ 20
`define OP_TIME_US 2000
`define OP_CYCLES (`OP_TIME_US * `CLK_MHZ)
`define CFG_UID_LAST 5'h03
`define CFG_DEVID 5'h06
`define CFG_WORD1 5'h07
`define CFG_WORD2 5'h08
`endif

// file: hdl/flash_seq_pkg.sv
// types shared by the flash self-write sequencer
package flash_seq_pkg;
  typedef enum logic [1:0] {U_IDLE, U_KEY1, U_ARMED} unlock_t;
  typedef enum logic [1:0] {S_IDLE, S_NOPS, S_WALK, S_BUSY} seq_state_t;
  typedef enum logic [2:0] {OP_NONE, OP_LOAD, OP_ERASE, OP_PROG, OP_READ} op_t;
endpackage

// file: hdl/write_latches.sv
// bank of 32 fourteen-bit write latches
`timescale 1ns/1ps
`include "flash_seq_cfg.svh"
module write_latches (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_we,
  input wire logic [4:0] i_widx,
  input wire logic [13:0] i_wdata,
  input wire logic i_clr,
  input wire logic [4:0] i_ridx,
  output logic [13:0] o_rdata
);
  logic [13:0] mem_q [`LATCH_COUNT];
  logic [13:0] mem_d [`LATCH_COUNT];

  // =====================================================
  // latch update: clear beats a load, the op is over
  always_comb begin
    for (int i = 0; i < `LATCH_COUNT; i++) begin
      mem_d[i] = mem_q[i];
      if (i_clr) begin
        mem_d[i] = `LATCH_BLANK; // see R13
      end else if (i_we && (i_widx == 5'(i))) begin
        mem_d[i] = i_wdata;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    for (int i = 0; i < `LATCH_COUNT; i++) begin
      mem_q[i] <= i_resetn ? mem_d[i] : `LATCH_BLANK;
    end
  end

  assign o_rdata = mem_q[i_ridx];
endmodule

// file: hdl/op_timer.sv
// one-shot timer for the flash erase and program time
`timescale 1ns/1ps
module op_timer #(
  parameter int unsigned P_CYCLES = 40000
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_start,
  output logic o_done
);
  logic [19:0] cnt_q;
  logic [19:0] cnt_d;

  // =====================================================
  // down counter, done pulses as it reaches the last cycle
  always_comb begin
    cnt_d = cnt_q;
    if (i_start) begin
      cnt_d = 20'(P_CYCLES);
    end else if (cnt_q != 20'h00000) begin
      cnt_d = cnt_q - 20'h00001;
    end
  end

  always_ff @(posedge i_clk) begin
    cnt_q <= i_resetn ? cnt_d : 20'h00000;
  end

  assign o_done = (cnt_q == 20'h00001);
endmodule

// file: hdl/flash_self_write_sequencer.sv
// flash self-write sequencer: unlock, latch load, row erase, program, read
`timescale 1ns/1ps
`include "flash_seq_cfg.svh"
module flash_self_write_sequencer #(
  parameter int unsigned P_OP_CYCLES = `OP_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_power_on,
  input wire logic i_key_wr,
  input wire logic [7:0] i_key_data,
  input wire logic i_other_access,
  input wire logic i_ctrl_wr,
  input wire logic i_ctrl_rd_set,
  input wire logic i_ctrl_wr_set,
  input wire logic i_ctrl_erase_sel,
  input wire logic i_ctrl_write_enable_bit,
  input wire logic i_ctrl_latch_load_only,
  input wire logic i_ctrl_config_space_select,
  input wire logic i_data_wr,
  input wire logic [13:0] i_data_wdata,
  input wire logic [14:0] i_addr,
  input wire logic i_instr_done,
  input wire logic i_abort_clr,
  input wire logic [13:0] i_fl_rdata,
  output logic [13:0] o_data,
  output logic o_read_start_bit,
  output logic o_write_start_bit,
  output logic o_erase_sel,
  output logic o_write_enable_bit,
  output logic o_latch_load_only,
  output logic o_config_space_select,
  output logic o_write_abort_flag,
  output logic o_force_nop,
  output logic o_core_stall,
  output logic o_fl_rd,
  output logic o_fl_erase,
  output logic o_fl_wr,
  output logic o_fl_cfg,
  output logic [14:0] o_fl_addr,
  output logic [13:0] o_fl_wdata
);
  import flash_seq_pkg::*;

  // =====================================================
  // configuration space decode, used for reads and writes
  function automatic logic cfg_readable(input logic [9:0] row, input logic [4:0] idx);
    cfg_readable = (row == `ROW_ZERO) && ((idx <= `CFG_UID_LAST) || (idx == `CFG_DEVID) ||
                   (idx == `CFG_WORD1) || (idx == `CFG_WORD2));
  endfunction
  function automatic logic cfg_writable(input logic [9:0] row, input logic [4:0] idx);
    cfg_writable = (row == `ROW_ZERO) && (idx <= `CFG_UID_LAST);
  endfunction
  unlock_t unlock_q, unlock_d;
  seq_state_t state_q, state_d;
  op_t op_q, op_d;
  logic [1:0] nop_q, nop_d;
  logic [4:0] idx_q, idx_d;
  logic [9:0] row_q, row_d;
  logic cfg_q, cfg_d;
  logic rd_pend_q, rd_pend_d;
  logic [13:0] data_q, data_d;
  logic wr_bit_q, wr_bit_d;
  logic rd_bit_q, rd_bit_d;
  logic erase_q, erase_d;
  logic wen_q, wen_d;
  logic llo_q, llo_d;
  logic cfg_sel_q, cfg_sel_d;
  logic abort_q, abort_d;
  logic fl_rd_q, fl_rd_d;
  logic fl_erase_q, fl_erase_d;
  logic fl_wr_q, fl_wr_d;
  logic fl_cfg_q, fl_cfg_d;
  logic [14:0] fl_addr_q, fl_addr_d;
  logic [13:0] fl_wdata_q, fl_wdata_d;
  logic start_ok, rd_start, latch_we, latch_clr, timer_start, timer_done;
  logic [13:0] latch_rdata;
  // =====================================================
  // unlock key tracking
  // any access that is not the next expected step drops back to idle, except a 55h key write, which restarts at the first key
  always_comb begin
    unlock_d = unlock_q;
    if (i_key_wr) begin
      if (i_key_data == `KEY_FIRST) begin
        unlock_d = U_KEY1; // see R1
      end else if ((i_key_data == `KEY_SECOND) && (unlock_q == U_KEY1)) begin
        unlock_d = U_ARMED; // see R1
      end else begin
        unlock_d = U_IDLE; // see R2
      end
    end else if (i_other_access || i_data_wr || i_ctrl_wr) begin
      unlock_d = U_IDLE; // see R2
    end
  end

  always_ff @(posedge i_clk) begin
    unlock_q <= i_resetn ? unlock_d : U_IDLE;
  end

  // the start bit counts only straight after the second key
  assign start_ok = i_ctrl_wr && i_ctrl_wr_set && (unlock_q == U_ARMED) &&
                    (state_q == S_IDLE); // see R1 see R16
  assign rd_start = i_ctrl_wr && i_ctrl_rd_set && !start_ok && (state_q == S_IDLE);

  // =====================================================
  // control bits; held while an operation runs so it cannot be retargeted
  always_comb begin
    erase_d = erase_q;
    wen_d = wen_q;
    llo_d = llo_q;
    cfg_sel_d = cfg_sel_q;
    if (i_ctrl_wr && (state_q == S_IDLE)) begin
      erase_d = i_ctrl_erase_sel;
      wen_d = i_ctrl_write_enable_bit;
      llo_d = i_ctrl_latch_load_only;
      cfg_sel_d = i_ctrl_config_space_select;
    end
  end

  always_ff @(posedge i_clk) begin
    erase_q <= i_resetn ? erase_d : 1'b0;
    wen_q <= i_resetn ? wen_d : 1'b0;
    llo_q <= i_resetn ? llo_d : 1'b0;
    cfg_sel_q <= i_resetn ? cfg_sel_d : 1'b0;
  end

  // =====================================================
  // write abort flag: survives a plain reset, cleared at power-on or by i_abort_clr
  // a reset landing while a write is in flight sets it; set beats i_abort_clr, power-on beats set
  always_comb begin
    abort_d = abort_q;
    if (i_abort_clr) begin
      abort_d = 1'b0;
    end
    if (!i_resetn && wr_bit_q) begin
      abort_d = 1'b1; // see R22
    end
    if (i_power_on) begin
      abort_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    abort_q <= abort_d;
  end

  // =====================================================
  // main sequence: forced no-ops, latch walk, erase/program wait
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    nop_d = nop_q;
    idx_d = idx_q;
    row_d = row_q;
    cfg_d = cfg_q;
    wr_bit_d = wr_bit_q;
    rd_bit_d = rd_bit_q;
    rd_pend_d = fl_rd_q;
    data_d = data_q;
    fl_rd_d = 1'b0;
    fl_erase_d = 1'b0;
    fl_wr_d = 1'b0;
    fl_cfg_d = fl_cfg_q;
    fl_addr_d = fl_addr_q;
    fl_wdata_d = fl_wdata_q;
    latch_we = 1'b0;
    latch_clr = 1'b0;
    timer_start = 1'b0;
    if (i_data_wr) begin
      data_d = i_data_wdata;
    end
    // flash answers the cycle after the read strobe
    if (rd_pend_q) begin
      data_d = (!cfg_q || cfg_readable(row_q, idx_q)) ? i_fl_rdata : 14'h0000; // see R24
    end
    case (state_q)
      S_IDLE: begin
        if (start_ok) begin
          wr_bit_d = 1'b1; // see R21
          row_d = i_addr[14:5]; // see R11
          idx_d = i_addr[4:0]; // see R11
          cfg_d = i_ctrl_config_space_select; // see R24
          nop_d = 2'h0;
          state_d = S_NOPS; // see R3
          if (!i_ctrl_write_enable_bit) begin
            op_d = OP_NONE; // see R25
          end else if (i_ctrl_erase_sel) begin
            op_d = OP_ERASE; // see R8
          end else if (i_ctrl_latch_load_only) begin
            op_d = OP_LOAD; // see R14
            latch_we = 1'b1; // see R14
          end else begin
            op_d = OP_PROG; // see R15
            latch_we = 1'b1; // see R15
          end
        end else if (rd_start) begin
          rd_bit_d = 1'b1;
          row_d = i_addr[14:5];
          idx_d = i_addr[4:0];
          cfg_d = i_ctrl_config_space_select;
          nop_d = 2'h0;
          op_d = OP_READ;
          state_d = S_NOPS;
        end
      end
      S_NOPS: begin
        if (i_instr_done) begin
          nop_d = nop_q + 2'h1;
          if ((op_q == OP_READ) && (nop_q == 2'h0)) begin
            fl_rd_d = 1'b1; // see R23
            fl_cfg_d = cfg_q; // see R24
            fl_addr_d = {row_q, idx_q};
          end
          if (nop_q == `NOP_LAST) begin
            if ((op_q == OP_ERASE) && !cfg_q) begin
              // whole row only, low bits forced to the row start
              fl_erase_d = 1'b1; // see R9
              fl_cfg_d = 1'b0;
              fl_addr_d = {row_q, `IDX_ZERO}; // see R9
              timer_start = 1'b1;
              state_d = S_BUSY; // see R4
            end else if (op_q == OP_PROG) begin
              idx_d = `IDX_ZERO;
              state_d = S_WALK; // see R4
            end else begin
              wr_bit_d = 1'b0; // see R5 see R21
              rd_bit_d = 1'b0; // see R21
              state_d = S_IDLE;
            end
          end
        end
      end
      S_WALK: begin
        // no erase strobe here: program only adds zeros to the row
        fl_wr_d = !cfg_q || cfg_writable(row_q, idx_q); // see R10 see R24
        fl_cfg_d = cfg_q;
        fl_addr_d = {row_q, idx_q}; // see R12
        fl_wdata_d = latch_rdata;
        idx_d = idx_q + 5'h01;
        if (idx_q == `LATCH_LAST) begin
          timer_start = 1'b1; // see R12
          state_d = S_BUSY;
        end
      end
      S_BUSY: begin
        if (timer_done) begin
          latch_clr = 1'b1; // see R13
          wr_bit_d = 1'b0; // see R21
          state_d = S_IDLE; // see R7
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_q <= S_IDLE;
      op_q <= OP_NONE;
      nop_q <= 2'h0;
      idx_q <= 5'h00;
      row_q <= 10'h000;
      cfg_q <= 1'b0;
      wr_bit_q <= 1'b0;
      rd_bit_q <= 1'b0;
      rd_pend_q <= 1'b0;
      data_q <= 14'h0000;
      fl_rd_q <= 1'b0;
      fl_erase_q <= 1'b0;
      fl_wr_q <= 1'b0;
      fl_cfg_q <= 1'b0;
      fl_addr_q <= 15'h0000;
      fl_wdata_q <= 14'h0000;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      nop_q <= nop_d;
      idx_q <= idx_d;
      row_q <= row_d;
      cfg_q <= cfg_d;
      wr_bit_q <= wr_bit_d;
      rd_bit_q <= rd_bit_d;
      rd_pend_q <= rd_pend_d;
      data_q <= data_d;
      fl_rd_q <= fl_rd_d;
      fl_erase_q <= fl_erase_d;
      fl_wr_q <= fl_wr_d;
      fl_cfg_q <= fl_cfg_d;
      fl_addr_q <= fl_addr_d;
      fl_wdata_q <= fl_wdata_d;
    end
  end

  // =====================================================
  // latch bank and operation timer
  write_latches u_latches (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_we(latch_we),
    .i_widx(i_addr[4:0]),
    .i_wdata(data_q),
    .i_clr(latch_clr),
    .i_ridx(idx_q),
    .o_rdata(latch_rdata)
  );

  op_timer #(
    .P_CYCLES(P_OP_CYCLES)
  ) u_timer (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_start(timer_start),
    .o_done(timer_done)
  );

  // =====================================================
  // core side: only instruction execution halts, clocks keep running
  // a read discards only its second instruction
  assign o_force_nop = (state_q == S_NOPS) &&
                       ((op_q != OP_READ) || (nop_q == `NOP_LAST)); // see R3 see R23
  assign o_core_stall = (state_q == S_WALK) || (state_q == S_BUSY); // see R4 see R6

  assign o_data = data_q;
  assign o_read_start_bit = rd_bit_q;
  assign o_write_start_bit = wr_bit_q;
  assign o_erase_sel = erase_q;
  assign o_write_enable_bit = wen_q;
  assign o_latch_load_only = llo_q;
  assign o_config_space_select = cfg_sel_q;
  assign o_write_abort_flag = abort_q;
  assign o_fl_rd = fl_rd_q;
  assign o_fl_erase = fl_erase_q;
  assign o_fl_wr = fl_wr_q;
  assign o_fl_cfg = fl_cfg_q;
  assign o_fl_addr = fl_addr_q;
  assign o_fl_wdata = fl_wdata_q;
endmodule

// file: verification/seq_checker_asserts.sv
// concurrent checks on the ports of the flash self-write sequencer
`timescale 1ns/1ps
module seq_checker (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ctrl_wr,
  input wire logic i_ctrl_wr_set,
  input wire logic [13:0] i_fl_rdata,
  input wire logic [13:0] o_data,
  input wire logic o_write_start_bit,
  input wire logic o_write_enable_bit,
  input wire logic o_latch_load_only,
  input wire logic o_force_nop,
  input wire logic o_core_stall,
  input wire logic o_fl_rd,
  input wire logic o_fl_cfg,
  input wire logic o_fl_erase,
  input wire logic o_fl_wr,
  input wire logic [14:0] o_fl_addr
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // ==========
  // helper logic
  // counts row writes of one operation; a runaway walk would pass the latch count
  logic [6:0] wr_cnt_q;
  logic [9:0] row;
  logic start_req;
  assign row = o_fl_addr[14:5];
  assign start_req = i_ctrl_wr && i_ctrl_wr_set;
  always_ff @(posedge i_clk) begin
    if (!i_resetn || !o_write_start_bit) begin
      wr_cnt_q <= 7'h00;
    end else if (o_fl_wr) begin
      wr_cnt_q <= wr_cnt_q + 7'h01;
    end
  end
  // ==========
  // properties
  sequence s_stall8;
    o_core_stall [*8];
  endsequence
  property p_nop_start;
    $rose(o_write_start_bit) |-> o_force_nop;
  endproperty
  property p_start_cause;
    $rose(o_write_start_bit) |-> $past(start_req);
  endproperty
  property p_load_no_stall;
    o_write_start_bit && o_latch_load_only |-> !o_core_stall;
  endproperty
  property p_erase_row;
    o_fl_erase |-> o_fl_addr[4:0] == 5'h00;
  endproperty
  property p_erase_stall;
    o_fl_erase |=> s_stall8;
  endproperty
  property p_wr_prog;
    o_fl_wr |-> o_write_start_bit && !o_latch_load_only;
  endproperty
  property p_wr_wen;
    o_fl_wr || o_fl_erase |-> o_write_enable_bit;
  endproperty
  property p_wr_count;
    wr_cnt_q <= 7'h20;
  endproperty
  property p_same_row;
    o_fl_wr && $past(o_fl_wr) |-> row == $past(row);
  endproperty
  property p_stall_clear;
    $fell(o_core_stall) |-> ##[0:1] !o_write_start_bit;
  endproperty
  property p_read_data;
    o_fl_rd && !o_fl_cfg |-> ##2 o_data == $past(i_fl_rdata);
  endproperty
  a_nop_start: assert property (p_nop_start) else $error("no forced no-op");
  a_start_cause: assert property (p_start_cause) else $error("start without request");
  a_load_no_stall: assert property (p_load_no_stall) else $error("load stalled");
  a_erase_row: assert property (p_erase_row) else $error("erase not row aligned");
  a_erase_stall: assert property (p_erase_stall) else $error("erase stall short");
  a_wr_prog: assert property (p_wr_prog) else $error("flash write on load");
  a_wr_wen: assert property (p_wr_wen) else $error("write without enable");
  a_wr_count: assert property (p_wr_count) else $error("too many row writes");
  a_same_row: assert property (p_same_row) else $error("walk left its row");
  a_stall_clear: assert property (p_stall_clear) else $error("start bit stuck");
  a_read_data: assert property (p_read_data) else $error("read data wrong");
endmodule

// file: verification/core_model.sv
// processor core model issuing register accesses to the sequencer
`timescale 1ns/1ps
module core_model (
  input wire logic i_clk,
  input wire logic i_stall,
  output logic o_key_wr,
  output logic [7:0] o_key_data,
  output logic o_other,
  output logic o_ctrl_wr,
  output logic o_rd_set,
  output logic o_wr_set,
  output logic o_erase,
  output logic o_wen,
  output logic o_llo,
  output logic o_cfg,
  output logic o_data_wr,
  output logic [13:0] o_wdata,
  output logic [14:0] o_addr,
  output logic o_instr_done,
  output logic o_abort_clr
);
  // ==========
  // idle state; interrupts are never taken, so only pulse_other splits the keys
  initial begin
    {o_key_wr, o_other, o_ctrl_wr, o_rd_set, o_wr_set, o_data_wr} = 6'h00;
    {o_erase, o_wen, o_llo, o_cfg, o_abort_clr} = 5'h00;
    o_key_data = 8'h00;
    o_wdata = 14'h0000;
    o_addr = 15'h0000;
  end
  // one instruction retires each cycle unless the core is halted
  always @(negedge i_clk) begin
    o_instr_done <= !i_stall;
  end
  // ==========
  // access tasks; released data lines show the inverse of the last value
  task automatic key(input logic [7:0] v);
    @(negedge i_clk);
    o_key_wr = 1'b1;
    o_key_data = v;
    @(negedge i_clk);
    o_key_wr = 1'b0;
    o_key_data = ~v;
  endtask
  task automatic ctrl(input logic rd, wr, er, wen, llo, cfg);
    @(negedge i_clk);
    {o_ctrl_wr, o_rd_set, o_wr_set} = {1'b1, rd, wr};
    {o_erase, o_wen, o_llo, o_cfg} = {er, wen, llo, cfg};
    @(negedge i_clk);
    {o_ctrl_wr, o_rd_set, o_wr_set} = 3'h0;
  endtask
  task automatic load(input logic [14:0] a, input logic [13:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_data_wr = 1'b1;
    o_wdata = d;
    @(negedge i_clk);
    o_data_wr = 1'b0;
    o_wdata = ~d;
  endtask
  task automatic pulse_other(input logic abort);
    @(negedge i_clk);
    {o_other, o_abort_clr} = {!abort, abort};
    @(negedge i_clk);
    {o_other, o_abort_clr} = 2'h0;
  endtask
endmodule

// file: verification/tb_flash_self_write_sequencer.sv
// self-checking testbench for the flash self-write sequencer
`timescale 1ns/1ps
`include "flash_seq_cfg.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module tb_flash_self_write_sequencer;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_power_on = 1'b1;
  logic key_wr, other, ctrl_wr, rd_set, wr_set, erase, wen, llo, cfg, data_wr, idone, aclr;
  logic [7:0] key_data;
  logic [13:0] wdata, o_data, o_fl_wdata, img [32];
  logic [13:0] fl_rdata = 14'h0000;
  logic [14:0] addr, o_fl_addr, eaddr;
  logic [9:0] wrow;
  logic o_write_start_bit, o_read_start_bit, o_force_nop, o_core_stall, o_write_abort_flag;
  logic o_fl_rd, o_fl_erase, o_fl_wr, o_erase_sel, o_config_space_select;
  int miscompares = 0, num_checks = 0, cyc = 0, nwr, ner, nnop, nst;
  always #25 i_clk = ~i_clk;
  flash_self_write_sequencer #(.P_OP_CYCLES(20)) DUT (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_power_on(i_power_on), .i_key_wr(key_wr),
    .i_key_data(key_data), .i_other_access(other), .i_ctrl_wr(ctrl_wr),
    .i_ctrl_rd_set(rd_set), .i_ctrl_wr_set(wr_set), .i_ctrl_erase_sel(erase),
    .i_ctrl_write_enable_bit(wen), .i_ctrl_latch_load_only(llo),
    .i_ctrl_config_space_select(cfg), .i_data_wr(data_wr), .i_data_wdata(wdata),
    .i_addr(addr), .i_instr_done(idone), .i_abort_clr(aclr), .i_fl_rdata(fl_rdata),
    .o_data(o_data), .o_read_start_bit(o_read_start_bit), .o_write_start_bit(o_write_start_bit),
    .o_erase_sel(o_erase_sel), .o_write_enable_bit(), .o_latch_load_only(),
    .o_config_space_select(o_config_space_select),
    .o_write_abort_flag(o_write_abort_flag), .o_force_nop(o_force_nop),
    .o_core_stall(o_core_stall), .o_fl_rd(o_fl_rd), .o_fl_erase(o_fl_erase), .o_fl_wr(o_fl_wr),
    .o_fl_cfg(), .o_fl_addr(o_fl_addr), .o_fl_wdata(o_fl_wdata));
  core_model u_core (
    .i_clk(i_clk), .i_stall(o_core_stall), .o_key_wr(key_wr), .o_key_data(key_data),
    .o_other(other), .o_ctrl_wr(ctrl_wr), .o_rd_set(rd_set), .o_wr_set(wr_set),
    .o_erase(erase), .o_wen(wen), .o_llo(llo), .o_cfg(cfg), .o_data_wr(data_wr),
    .o_wdata(wdata), .o_addr(addr), .o_instr_done(idone), .o_abort_clr(aclr));
  // ==========
  // flash array answer: registered on the strobe, so it stands the whole cycle after it
  always @(posedge i_clk) begin
    fl_rdata <= o_fl_rd ? 14'h2B5C : 14'h14A3;
  end
  // array monitor and hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      test_done();
    end
    if (o_fl_wr) begin
      nwr++;
      wrow = o_fl_addr[14:5];
      img[o_fl_addr[4:0]] = o_fl_wdata;
    end
    if (o_fl_erase) begin
      ner++;
      eaddr = o_fl_addr;
    end
    nnop += o_force_nop;
    nst += o_core_stall;
  end
  // ==========
  // tasks; brk 1 splits the keys, 2 sends a bad second key, 3 returns at once,
  // 4 targets the configuration space
  task automatic op(input logic er, w, l, input logic [14:0] a, input logic [13:0] d, int brk);
    {nwr, ner, nnop, nst} = '0;
    u_core.ctrl(1'b0, 1'b0, er, w, l, brk == 4);
    u_core.load(a, d);
    u_core.key(8'h55);
    if (brk == 1) u_core.pulse_other(1'b0);
    u_core.key(brk == 2 ? 8'h55 : 8'hAA);
    u_core.ctrl(1'b0, 1'b1, er, w, l, brk == 4);
    if (brk != 3) wait_idle();
  endtask
  task automatic wait_idle();
    repeat (300) begin
      @(negedge i_clk);
      if (!o_write_start_bit && !o_read_start_bit && !o_core_stall) break;
    end
    repeat (2) @(negedge i_clk);
  endtask
  task automatic end_test(input string name);
    $display("test %s finished", name);
  endtask
  task automatic test_done();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========
  // main sequence
  logic [14:0] ra [3] = '{15'h00A3, 15'h0005, 15'h0006};
  logic [13:0] rexp [3] = '{14'h2B5C, 14'h0000, 14'h2B5C};
  initial begin
    repeat (3) @(negedge i_clk);
    i_resetn = 1'b1;
    i_power_on = 1'b0;
    `CHK(o_write_start_bit, 1'b0)
    `CHK(o_write_abort_flag, 1'b0)
    end_test("reset");
    op(1'b0, 1'b1, 1'b1, 15'h00A3, 14'h1234, 0);
    `CHK(nnop, 2)
    `CHK(nst + nwr, 0)
    op(1'b0, 1'b1, 1'b0, 15'h00A4, 14'h0ABC, 0);
    `CHK(nwr, 32)
    `CHK(wrow, 10'h005)
    `CHK(img[3], 14'h1234)
    `CHK(img[4], 14'h0ABC)
    `CHK(img[0], `LATCH_BLANK)
    `CHK(nst >= 20 && ner == 0, 1'b1)
    end_test("load_program");
    for (int k = 0; k < 3; k++) begin
      op(1'b0, k != 2, 1'b1, 15'h00A2, 14'h0777, k == 2 ? 0 : k + 1);
      `CHK(nst + nwr + ner, 0)
    end
    op(1'b0, 1'b1, 1'b0, 15'h00BF, 14'h0155, 0);
    `CHK(img[2], `LATCH_BLANK)
    `CHK(img[3], `LATCH_BLANK)
    `CHK(img[31], 14'h0155)
    end_test("refused");
    op(1'b1, 1'b1, 1'b0, 15'h0127, 14'h0000, 0);
    `CHK(ner, 1)
    `CHK(eaddr, 15'h0120)
    `CHK(nwr, 0)
    `CHK(nnop == 2 && nst >= 20, 1'b1)
    `CHK(o_erase_sel, 1'b1)
    end_test("erase");
    op(1'b0, 1'b1, 1'b0, 15'h0002, 14'h0AAA, 4);
    `CHK(nwr, 4)
    `CHK(img[2], 14'h0AAA)
    `CHK(o_config_space_select, 1'b1)
    end_test("config");
    for (int k = 0; k < 3; k++) begin
      u_core.load(ra[k], 14'h0000);
      u_core.ctrl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, k != 0);
      wait_idle();
      `CHK(o_data, rexp[k])
    end
    end_test("read");
    op(1'b0, 1'b1, 1'b0, 15'h0040, 14'h0001, 3);
    repeat (8) @(negedge i_clk);
    `CHK(o_core_stall, 1'b1)
    i_resetn = 1'b0;
    repeat (3) @(negedge i_clk);
    i_resetn = 1'b1;
    `CHK(o_write_abort_flag, 1'b1)
    `CHK(o_core_stall, 1'b0)
    u_core.pulse_other(1'b1);
    `CHK(o_write_abort_flag, 1'b0)
    end_test("abort");
    test_done();
  end
endmodule
bind flash_self_write_sequencer seq_checker u_chk (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_ctrl_wr(i_ctrl_wr), .i_ctrl_wr_set(i_ctrl_wr_set),
  .i_fl_rdata(i_fl_rdata), .o_data(o_data), .o_write_start_bit(o_write_start_bit),
  .o_write_enable_bit(o_write_enable_bit), .o_latch_load_only(o_latch_load_only),
  .o_force_nop(o_force_nop), .o_core_stall(o_core_stall), .o_fl_rd(o_fl_rd),
  .o_fl_cfg(o_fl_cfg), .o_fl_erase(o_fl_erase), .o_fl_wr(o_fl_wr), .o_fl_addr(o_fl_addr));
